// *** core/chain_pkg.sv ***
// Constants, types and helpers for the daisy-chain packet layer
// Overview of operation
// - Stop character is unencoded 54h, parity 1, six high and six low bits.
// - Low-Z idle drives both outputs to 0; high-Z idle leaves both undriven.
// - Leaving idle, positive output goes high briefly before start; no idle delay.
// - Lengths: assign 8, writes 14, single read 16, host-path commands 6.
// - Broadcast read 12+4z, block read 12+4BS; fill bytes only reserve slots.
// - Up-path command sets host-path selector to 1; down-path clears it.
// - Fixed codes: assign 57h, alert 21h, writes 02h, read 03h, 09h, 08h.
// - Single commands carry address in 7:3; other devices ignore them.
// - Block read holds block size 1-32 in bits 7:3, low bits 110.
// - Invalid register or device address: no access, packet forwarded unchanged.
// - Register address is one byte; register data is two bytes, 16 bits.
// - Data-check byte only in reads; single read changed by addressed device.
// - Host seeds data-check byte; each device ORs in its status and forwards.
// - Data-check bit 7 set by a device seeing a PEC error this transaction.
// - Bit 6 is OR of both enabled self-diagnostic alerts.
// - Bit 5 is reset alert OR six enabled miscellaneous alerts.
// - Bits 4..1 enabled aux over, aux under, cell over, cell under; bit 0 zero.
// - Masking an alert from data-check byte never clears the flag itself.
// - Scan-done and PEC roll-up never enter the byte; reset alert unmaskable.
// - PEC error sets path error flag, which sets the roll-up flag.
// - PEC in all but assign; alive byte in reads and writes only when enabled.
// - Data character: nibble LSB first, each bit then complement, parity 0.
// - Start character is unencoded 15h with parity 1.
// - A write is carried out only if no PEC error was found.
package chain_pkg;

  // Framing and command codes
  localparam logic [7:0] PREAMBLE_CHAR = 8'h15;
  localparam logic [7:0] STOP_CHAR     = 8'h54;
  localparam logic       FRAME_PARITY  = 1'h1;
  localparam logic       DATA_PARITY   = 1'h0;
  localparam logic [7:0] CMD_ADDR_ASSIGN = 8'h57;
  localparam logic [7:0] CMD_ALERT       = 8'h21;
  localparam logic [7:0] CMD_BCAST_WRITE = 8'h02;
  localparam logic [7:0] CMD_BCAST_READ  = 8'h03;
  localparam logic [7:0] CMD_DOWN_HOST   = 8'h09;
  localparam logic [7:0] CMD_UP_HOST     = 8'h08;
  localparam logic [2:0] LOW_SINGLE_WRITE = 3'h4;
  localparam logic [2:0] LOW_SINGLE_READ  = 3'h5;
  localparam logic [2:0] LOW_BLOCK_READ   = 3'h6;

  // Packet byte positions
  localparam logic [7:0] IDX_CMD       = 8'h00;
  localparam logic [7:0] IDX_REG       = 8'h01;
  localparam logic [7:0] IDX_DATA_LO   = 8'h02;
  localparam logic [7:0] IDX_DATA_HI   = 8'h03;
  localparam logic [7:0] WRITE_BYTES   = 8'h05;
  localparam logic [7:0] HOST_BYTES    = 8'h02;
  localparam logic [5:0] BLOCK_MAX     = 6'h20;

  // Alert flag positions on the alert and enable vectors
  localparam int AL_DIAG_A   = 0;
  localparam int AL_DIAG_B   = 1;
  localparam int AL_MISMATCH = 2;
  localparam int AL_BLK_OV   = 3;
  localparam int AL_BLK_UV   = 4;
  localparam int AL_INTF     = 5;
  localparam int AL_CAL      = 6;
  localparam int AL_BAL      = 7;
  localparam int AL_AUX_OV   = 8;
  localparam int AL_AUX_UV   = 9;
  localparam int AL_CELL_OV  = 10;
  localparam int AL_CELL_UV  = 11;
  localparam int ALERT_COUNT = 12;

  // Reset values
  localparam logic HOST_PATH_RESET = 1'h1;
  localparam logic READY_RESET     = 1'h1;

  // Bit timing
  localparam int CLK_HZ      = 25000000;
  localparam int BAUD_BPS    = 1000000;
  localparam int BIT_CYCLES  = CLK_HZ / BAUD_BPS;
  localparam logic [5:0] BIT_LAST  = 6'(BIT_CYCLES - 1);
  localparam logic [3:0] CHAR_BITS = 4'hc;

  typedef enum logic [3:0] {
    K_NONE, K_ADDR, K_BWRITE, K_SWRITE, K_BREAD, K_SREAD, K_BLOCK,
    K_UP_PATH_HOST_CMD, K_DOWN_PATH_HOST_CMD, K_OTHER
  } cmd_kind_type;

  typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_SHIFT} tx_state_type;

  // Classify a command byte for this device
  function automatic cmd_kind_type decode_cmd(input logic [7:0] cmd,
                                              input logic [4:0] own);
    cmd_kind_type k;
    k = K_OTHER;
    case (cmd)
      CMD_ADDR_ASSIGN: k = K_ADDR;
      CMD_BCAST_WRITE: k = K_BWRITE;
      CMD_BCAST_READ:  k = K_BREAD;
      CMD_UP_HOST:     k = K_UP_PATH_HOST_CMD;
      CMD_DOWN_HOST:   k = K_DOWN_PATH_HOST_CMD;
      default: begin
        if (cmd[2:0] == LOW_BLOCK_READ)
          k = K_BLOCK;
        else if (cmd[7:3] == own && cmd[2:0] == LOW_SINGLE_READ)
          k = K_SREAD;
        else if (cmd[7:3] == own && cmd[2:0] == LOW_SINGLE_WRITE)
          k = K_SWRITE;
      end
    endcase
    return k;
  endfunction

  // Unencoded framing character, LSB first from start bit
  function automatic logic [11:0] frame_char(input logic [7:0] b);
    return {2'h3, FRAME_PARITY, b, 1'h0};
  endfunction

  // Manchester data character carrying one nibble
  function automatic logic [11:0] data_char(input logic [3:0] n);
    return {2'h3, DATA_PARITY, ~n[3], n[3], ~n[2], n[2],
            ~n[1], n[1], ~n[0], n[0], 1'h0};
  endfunction

endpackage

// *** core/chain_packet_layer.sv ***
// Packet layer of one daisy-chained device: parse, substitute, re-send
`timescale 1ns/1ps
module chain_packet_layer (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        RX_START,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_BYTE,
  output logic             RX_READY,
  input  wire logic        RX_STOP,
  input  wire logic        RX_CRC_ERROR,
  input  wire logic        RX_PATH_UP,
  input  wire logic [4:0]  DEVICE_ADDRESS,
  input  wire logic [5:0]  DEVICE_COUNT,
  input  wire logic        ALIVE_COUNTER_ENABLE,
  input  wire logic        IDLE_HIGH_Z,
  input  wire logic [11:0] ALERT_FLAGS,
  input  wire logic [11:0] ALERT_ENABLE,
  input  wire logic        POWER_ON_RESET_ALERT,
  output logic [7:0]       REG_ADDR,
  input  wire logic        REG_VALID,
  input  wire logic [15:0] READ_DATA,
  output logic             WRITE_STROBE,
  output logic [15:0]      WRITE_DATA,
  output logic             HOST_PATH_SELECT,
  input  wire logic        CLEAR_CRC_FLAGS,
  output logic             UP_PATH_CRC_ERROR,
  output logic             DOWN_PATH_CRC_ERROR,
  output logic             CRC_ERROR_ROLLUP,
  output logic             TX_POSITIVE_PIN,
  output logic             TX_NEGATIVE_PIN,
  output logic             TX_POSITIVE_OE,
  output logic             TX_NEGATIVE_OE
);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chain_pkg::cmd_kind_type kind, next_kind;
  logic [7:0]  idx, next_idx;
  logic [5:0]  pairs, next_pairs;
  logic        pec_err, next_pec_err;
  logic        skip, next_skip;
  logic [7:0]  next_reg_addr;
  logic        next_strobe;
  logic [15:0] next_wdata;
  logic        next_host;
  logic [7:0]  byte_out;
  logic        take;
  logic [7:0]  fill_off;
  logic [7:0]  dc_idx;
  logic        is_read;
  logic        in_fill;
  logic        serve;
  logic [7:0]  status;
  logic        crc_now;

  // Masked alert summary for the data-check byte
  assign crc_now = pec_err | RX_CRC_ERROR;
  assign status[7] = crc_now;
  assign status[6] = (ALERT_FLAGS[chain_pkg::AL_DIAG_A]
                      & ALERT_ENABLE[chain_pkg::AL_DIAG_A])
                   | (ALERT_FLAGS[chain_pkg::AL_DIAG_B]
                      & ALERT_ENABLE[chain_pkg::AL_DIAG_B]);
  assign status[5] = POWER_ON_RESET_ALERT
                   | (|(ALERT_FLAGS[chain_pkg::AL_BAL:chain_pkg::AL_MISMATCH]
                      & ALERT_ENABLE[chain_pkg::AL_BAL:chain_pkg::AL_MISMATCH]));
  // Flags are only read here, so masking leaves them intact
  assign status[4] = ALERT_FLAGS[chain_pkg::AL_AUX_OV]
                   & ALERT_ENABLE[chain_pkg::AL_AUX_OV];
  assign status[3] = ALERT_FLAGS[chain_pkg::AL_AUX_UV]
                   & ALERT_ENABLE[chain_pkg::AL_AUX_UV];
  assign status[2] = ALERT_FLAGS[chain_pkg::AL_CELL_OV]
                   & ALERT_ENABLE[chain_pkg::AL_CELL_OV];
  assign status[1] = ALERT_FLAGS[chain_pkg::AL_CELL_UV]
                   & ALERT_ENABLE[chain_pkg::AL_CELL_UV];
  assign status[0] = 1'h0;

  // Packet position decode
  assign take     = RX_VALID & RX_READY & ~RX_START;
  assign fill_off = idx - chain_pkg::IDX_DATA_LO;
  assign dc_idx   = {1'h0, pairs, 1'h0} + chain_pkg::IDX_DATA_LO;
  assign is_read  = (kind == chain_pkg::K_BREAD) | (kind == chain_pkg::K_SREAD)
                  | (kind == chain_pkg::K_BLOCK);
  assign in_fill  = is_read & (idx >= chain_pkg::IDX_DATA_LO) & (idx < dc_idx);
  assign serve    = in_fill & REG_VALID & ((idx == chain_pkg::IDX_DATA_LO) | ~skip)
                  & ((kind != chain_pkg::K_BREAD)
                     | (fill_off[6:1] == {1'h0, DEVICE_ADDRESS}));

  // Receive parser: command, address, data, substitution, commit
  always_comb begin
    next_kind     = kind;
    next_idx      = idx;
    next_pairs    = pairs;
    next_pec_err  = pec_err | RX_CRC_ERROR;
    next_skip     = skip;
    next_reg_addr = REG_ADDR;
    next_strobe   = 1'h0;
    next_wdata    = WRITE_DATA;
    next_host     = HOST_PATH_SELECT;
    byte_out      = RX_BYTE;
    if (RX_START) begin
      next_kind    = chain_pkg::K_NONE;
      next_idx     = chain_pkg::IDX_CMD;
      next_pec_err = RX_CRC_ERROR;
      next_skip    = 1'h0;
    end
    if (take) begin
      next_idx = (idx == 8'hff) ? idx : idx + 8'h01;
      if (idx == chain_pkg::IDX_CMD) begin
        next_kind = chain_pkg::decode_cmd(RX_BYTE, DEVICE_ADDRESS);
        case (chain_pkg::decode_cmd(RX_BYTE, DEVICE_ADDRESS))
          chain_pkg::K_BREAD: next_pairs = DEVICE_COUNT;
          chain_pkg::K_SREAD: next_pairs = 6'h01;
          chain_pkg::K_BLOCK: next_pairs = (RX_BYTE[7:3] == 5'h00) ?
                              chain_pkg::BLOCK_MAX : {1'h0, RX_BYTE[7:3]};
          default:            next_pairs = 6'h00;
        endcase
      end
      if (idx == chain_pkg::IDX_REG)
        next_reg_addr = RX_BYTE;
      if (idx == chain_pkg::IDX_DATA_LO) begin
        next_skip = ~REG_VALID;
        if (kind == chain_pkg::K_BWRITE || kind == chain_pkg::K_SWRITE)
          next_wdata[7:0] = RX_BYTE;
      end
      if (idx == chain_pkg::IDX_DATA_HI)
        if (kind == chain_pkg::K_BWRITE || kind == chain_pkg::K_SWRITE)
          next_wdata[15:8] = RX_BYTE;
      if (serve)
        byte_out = fill_off[0] ? READ_DATA[15:8] : READ_DATA[7:0];
      if (in_fill && fill_off[0] && kind == chain_pkg::K_BLOCK)
        next_reg_addr = REG_ADDR + 8'h01;
      if (is_read && idx == dc_idx && !skip)
        byte_out = RX_BYTE | status;
    end
    if (RX_STOP && !RX_START) begin
      if (!crc_now) begin
        if ((kind == chain_pkg::K_BWRITE || kind == chain_pkg::K_SWRITE)
            && REG_VALID
            && idx == chain_pkg::WRITE_BYTES + {7'h00, ALIVE_COUNTER_ENABLE})
          next_strobe = 1'h1;
        if (kind == chain_pkg::K_UP_PATH_HOST_CMD && idx >= chain_pkg::HOST_BYTES)
          next_host = 1'h1;
        if (kind == chain_pkg::K_DOWN_PATH_HOST_CMD && idx >= chain_pkg::HOST_BYTES)
          next_host = 1'h0;
      end
      next_kind = chain_pkg::K_NONE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      kind             <= chain_pkg::K_NONE;
      idx              <= chain_pkg::IDX_CMD;
      pairs            <= 6'h00;
      pec_err          <= 1'h0;
      skip             <= 1'h0;
      REG_ADDR         <= 8'h00;
      WRITE_STROBE     <= 1'h0;
      WRITE_DATA       <= 16'h0000;
      HOST_PATH_SELECT <= chain_pkg::HOST_PATH_RESET;
    end else begin
      kind             <= next_kind;
      idx              <= next_idx;
      pairs            <= next_pairs;
      pec_err          <= next_pec_err;
      skip             <= next_skip;
      REG_ADDR         <= next_reg_addr;
      WRITE_STROBE     <= next_strobe;
      WRITE_DATA       <= next_wdata;
      HOST_PATH_SELECT <= next_host;
    end
  end

  a_write_crc_ok: assert property (WRITE_STROBE |-> !pec_err)
    else $error("write committed after a PEC error");
  a_host_up_sel: assert property (
    RX_STOP && !RX_START && !crc_now && kind == chain_pkg::K_UP_PATH_HOST_CMD
    && idx >= chain_pkg::HOST_BYTES |=> HOST_PATH_SELECT)
    else $error("up-path command did not set selector");
  a_other_device: assert property (
    take && idx == chain_pkg::IDX_CMD && RX_BYTE[2:0] == chain_pkg::LOW_SINGLE_READ
    && RX_BYTE[7:3] != DEVICE_ADDRESS |=> kind == chain_pkg::K_OTHER)
    else $error("read for another device was accepted");
  c_write_done: cover property (WRITE_STROBE);
  c_host_down: cover property ($fell(HOST_PATH_SELECT));
  c_dc_sub: cover property (take && is_read && idx == dc_idx && |status);

  // Path error flags; a new error wins over a clear
  logic next_up_err, next_dn_err;
  always_comb begin
    next_up_err = (UP_PATH_CRC_ERROR & ~CLEAR_CRC_FLAGS)
                | (RX_CRC_ERROR & RX_PATH_UP);
    next_dn_err = (DOWN_PATH_CRC_ERROR & ~CLEAR_CRC_FLAGS)
                | (RX_CRC_ERROR & ~RX_PATH_UP);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      UP_PATH_CRC_ERROR   <= 1'h0;
      DOWN_PATH_CRC_ERROR <= 1'h0;
      CRC_ERROR_ROLLUP    <= 1'h0;
    end else begin
      UP_PATH_CRC_ERROR   <= next_up_err;
      DOWN_PATH_CRC_ERROR <= next_dn_err;
      CRC_ERROR_ROLLUP    <= next_up_err | next_dn_err;
    end
  end

  a_crc_rollup: assert property (
    RX_CRC_ERROR && RX_PATH_UP |=> UP_PATH_CRC_ERROR && CRC_ERROR_ROLLUP)
    else $error("PEC error not flagged on up path");

  // Transmitter: one-byte hold, framing pend flags, bit serializer
  chain_pkg::tx_state_type tx_state, next_tx_state;
  logic [7:0]  hold, next_hold;
  logic        hold_full, next_hold_full;
  logic        hi_nib, next_hi_nib;
  logic        sop_pend, next_sop_pend;
  logic        eop_pend, next_eop_pend;
  logic [11:0] shreg, next_shreg;
  logic [3:0]  bits_left, next_bits_left;
  logic [5:0]  cnt, next_cnt;
  logic        next_ready, next_pos, next_neg, next_oe;
  logic        bit_en, need_char, have_char;
  logic [11:0] new_char;

  assign bit_en    = (cnt == chain_pkg::BIT_LAST);
  assign need_char = (tx_state == chain_pkg::TX_IDLE)
                   | ((tx_state == chain_pkg::TX_SHIFT) & bit_en
                      & (bits_left == 4'h1));
  assign have_char = hold_full | eop_pend | sop_pend;

  always_comb begin
    next_tx_state  = tx_state;
    next_hold      = hold;
    next_hold_full = hold_full;
    next_hi_nib    = hi_nib;
    next_sop_pend  = sop_pend | RX_START;
    next_eop_pend  = eop_pend | (RX_STOP & ~RX_START);
    next_shreg     = shreg;
    next_bits_left = bits_left;
    next_cnt       = bit_en ? 6'h00 : cnt + 6'h01;
    new_char       = chain_pkg::data_char(hi_nib ? hold[7:4] : hold[3:0]);
    if (take) begin
      next_hold      = byte_out;
      next_hold_full = 1'h1;
      next_hi_nib    = 1'h0;
    end
    if (tx_state == chain_pkg::TX_LEAD && bit_en)
      next_tx_state = chain_pkg::TX_SHIFT;
    if (tx_state == chain_pkg::TX_SHIFT && bit_en) begin
      next_shreg     = {1'h1, shreg[11:1]};
      next_bits_left = bits_left - 4'h1;
    end
    if (need_char) begin
      if (!have_char) begin
        next_tx_state = chain_pkg::TX_IDLE;
      end else begin
        if (hold_full) begin
          next_hi_nib    = ~hi_nib;
          next_hold_full = ~hi_nib;
        end else if (eop_pend) begin
          new_char      = chain_pkg::frame_char(chain_pkg::STOP_CHAR);
          next_eop_pend = 1'h0;
        end else begin
          new_char      = chain_pkg::frame_char(chain_pkg::PREAMBLE_CHAR);
          next_sop_pend = RX_START;
        end
        next_shreg     = new_char;
        next_bits_left = chain_pkg::CHAR_BITS;
        if (tx_state == chain_pkg::TX_IDLE) begin
          next_tx_state = chain_pkg::TX_LEAD;
          next_cnt      = 6'h00;
        end
      end
    end
    next_ready = ~next_hold_full & ~next_sop_pend;
    case (next_tx_state)
      chain_pkg::TX_LEAD: begin
        next_pos = 1'h1;
        next_neg = 1'h0;
        next_oe  = 1'h1;
      end
      chain_pkg::TX_SHIFT: begin
        next_pos = next_shreg[0];
        next_neg = ~next_shreg[0];
        next_oe  = 1'h1;
      end
      default: begin
        next_pos = 1'h0;
        next_neg = 1'h0;
        next_oe  = ~IDLE_HIGH_Z;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tx_state        <= chain_pkg::TX_IDLE;
      hold            <= 8'h00;
      hold_full       <= 1'h0;
      hi_nib          <= 1'h0;
      sop_pend        <= 1'h0;
      eop_pend        <= 1'h0;
      shreg           <= 12'hfff;
      bits_left       <= 4'h0;
      cnt             <= 6'h00;
      RX_READY        <= chain_pkg::READY_RESET;
      TX_POSITIVE_PIN <= 1'h0;
      TX_NEGATIVE_PIN <= 1'h0;
      TX_POSITIVE_OE  <= 1'h0;
      TX_NEGATIVE_OE  <= 1'h0;
    end else begin
      tx_state        <= next_tx_state;
      hold            <= next_hold;
      hold_full       <= next_hold_full;
      hi_nib          <= next_hi_nib;
      sop_pend        <= next_sop_pend;
      eop_pend        <= next_eop_pend;
      shreg           <= next_shreg;
      bits_left       <= next_bits_left;
      cnt             <= next_cnt;
      RX_READY        <= next_ready;
      TX_POSITIVE_PIN <= next_pos;
      TX_NEGATIVE_PIN <= next_neg;
      TX_POSITIVE_OE  <= next_oe;
      TX_NEGATIVE_OE  <= next_oe;
    end
  end

  a_idle_low_z: assert property (
    tx_state == chain_pkg::TX_IDLE && $past(!IDLE_HIGH_Z) && !$past(RST)
    |-> !TX_POSITIVE_PIN && !TX_NEGATIVE_PIN && TX_POSITIVE_OE)
    else $error("low-Z idle not driven low");
  a_idle_high_z: assert property (
    tx_state == chain_pkg::TX_IDLE && $past(IDLE_HIGH_Z)
    |-> !TX_POSITIVE_OE && !TX_NEGATIVE_OE)
    else $error("high-Z idle still driving");
  a_lead_high: assert property (
    tx_state == chain_pkg::TX_LEAD |-> TX_POSITIVE_PIN
    ##[1:25] tx_state == chain_pkg::TX_SHIFT)
    else $error("lead-in high missing or too long");
  a_char_balance: assert property (
    $changed(bits_left) && bits_left == chain_pkg::CHAR_BITS
    |-> $countones(shreg) == 6 && !shreg[0])
    else $error("character not balanced");
  a_ready_hold: assert property (RX_READY |-> !hold_full && !sop_pend)
    else $error("ready while holding a byte");
  a_dc_or_only: assert property (
    take && is_read && idx == dc_idx |=>
    ((hold & $past(RX_BYTE)) == $past(RX_BYTE)))
    else $error("data-check byte lost a seed bit");
  c_high_z_idle: cover property (tx_state == chain_pkg::TX_IDLE && !TX_POSITIVE_OE);
  c_frame_start: cover property (tx_state == chain_pkg::TX_LEAD);

endmodule

// *** sim/chain_line_monitor.sv ***
// Line receiver model: rebuilds characters from the positive pin
`timescale 1ns/1ps
module chain_line_monitor (
  input wire logic CORE_CLK,
  input wire logic LINE_POS,
  input wire logic LINE_NEG,
  input wire logic LINE_OE
);
  logic [11:0] chars [0:255];
  int          count = 0;

  // Start edge, then mid-bit samples, LSB first
  // A drop to idle also falls; only a real start bit has NEG high
  always begin
    @(negedge LINE_POS);
    repeat (chain_pkg::BIT_CYCLES / 2) @(negedge CORE_CLK);
    if (LINE_OE === 1'h1 && LINE_NEG === 1'h1) begin
      for (int i = 0; i < 12; i++) begin
        if (i > 0)
          repeat (chain_pkg::BIT_CYCLES) @(negedge CORE_CLK);
        chars[count][i] = LINE_POS;
      end
      count++;
    end
  end
endmodule

// *** sim/tb.sv ***
// Bench for the packet layer: packets in, line characters out
`timescale 1ns/1ps
module tb;
  logic        CORE_CLK = 0;
  logic        RST = 1;
  logic        RX_START = 0;
  logic        RX_VALID = 0;
  logic        RX_STOP = 0;
  logic        RX_CRC_ERROR = 0;
  logic [7:0]  RX_BYTE = 8'h0;
  logic        ALIVE_COUNTER_ENABLE = 0;
  logic        IDLE_HIGH_Z = 0;
  logic [11:0] ALERT_FLAGS = 12'hfff;
  logic [11:0] ALERT_ENABLE = 12'ha5a;
  logic        POWER_ON_RESET_ALERT = 0;
  logic        CLEAR_CRC_FLAGS = 0;
  logic        RX_PATH_UP = 1;
  logic        REG_VALID = 1;
  logic        RX_READY, WRITE_STROBE, HOST_PATH_SELECT, CRC_ERROR_ROLLUP;
  logic        UP_PATH_CRC_ERROR, DOWN_PATH_CRC_ERROR;
  logic        TX_POSITIVE_PIN, TX_NEGATIVE_PIN;
  logic        TX_POSITIVE_OE, TX_NEGATIVE_OE;
  logic [7:0]  REG_ADDR;
  logic [15:0] WRITE_DATA;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          strobes = 0;
  int          base;

  chain_packet_layer dut (
    .CORE_CLK, .RST, .RX_START, .RX_VALID, .RX_BYTE, .RX_READY, .RX_STOP,
    .RX_CRC_ERROR, .RX_PATH_UP, .DEVICE_ADDRESS(5'h03),
    .DEVICE_COUNT(6'h04), .ALIVE_COUNTER_ENABLE, .IDLE_HIGH_Z, .ALERT_FLAGS,
    .ALERT_ENABLE, .POWER_ON_RESET_ALERT, .REG_ADDR, .REG_VALID,
    .READ_DATA(16'hbeef), .WRITE_STROBE, .WRITE_DATA, .HOST_PATH_SELECT,
    .CLEAR_CRC_FLAGS, .UP_PATH_CRC_ERROR, .DOWN_PATH_CRC_ERROR,
    .CRC_ERROR_ROLLUP, .TX_POSITIVE_PIN, .TX_NEGATIVE_PIN, .TX_POSITIVE_OE,
    .TX_NEGATIVE_OE);

  chain_line_monitor mon (.CORE_CLK, .LINE_POS(TX_POSITIVE_PIN),
                          .LINE_NEG(TX_NEGATIVE_PIN),
                          .LINE_OE(TX_POSITIVE_OE));

  // Clock and write pulse count
  always #20 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) if (WRITE_STROBE === 1'h1) strobes++;

  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic give_up;
    mismatches++;
    report_and_stop;
  endtask

  // Expected data character for one nibble
  function automatic logic [11:0] dch(input logic [3:0] v);
    return {3'h6, ~v[3], v[3], ~v[2], v[2], ~v[1], v[1], ~v[0], v[0], 1'h0};
  endfunction

  // Offer one byte, held until taken at a rising edge with ready high
  task automatic send_byte(input logic [7:0] b);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge CORE_CLK);
      if (RX_READY === 1'h1) break;
    end
    if (i == 3000) give_up;
    RX_VALID = 1;
    RX_BYTE = b;
    @(negedge CORE_CLK);
    RX_VALID = 0;
  endtask

  // Send a packet, then compare the characters put on the line
  task automatic xfer(input logic [63:0] b, input int n, input logic err,
                      input logic [63:0] e);
    int i;
    base = mon.count;
    @(negedge CORE_CLK);
    RX_START = 1;
    @(negedge CORE_CLK);
    RX_START = 0;
    for (int k = 0; k < n; k++) begin
      send_byte(b[63-8*k -: 8]);
      RX_CRC_ERROR = err && k == 1;
    end
    @(negedge CORE_CLK);
    RX_CRC_ERROR = 0;
    RX_STOP = 1;
    @(negedge CORE_CLK);
    RX_STOP = 0;
    for (i = 0; i < 20000 && mon.count < base + 2 * n + 2; i++)
      @(negedge CORE_CLK);
    if (i == 20000) give_up;
    chk("preamble", {3'h7, 8'h15, 1'h0}, mon.chars[base]);
    for (int k = 0; k < n; k++) begin
      chk("low nibble", dch(e[59-8*k -: 4]), mon.chars[base+1+2*k]);
      chk("high nibble", dch(e[63-8*k -: 4]), mon.chars[base+2+2*k]);
    end
    chk("stop", {3'h7, 8'h54, 1'h0}, mon.chars[base+2*n+1]);
    repeat (40) @(negedge CORE_CLK);
    chk("idle pins", 16'h0, {TX_POSITIVE_PIN, TX_NEGATIVE_PIN});
    chk("idle oe", 16'h3, {TX_POSITIVE_OE, TX_NEGATIVE_OE});
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge CORE_CLK);
    RST = 0;
    chk("host sel reset", 16'h1, HOST_PATH_SELECT);
    xfer(64'h09a1 << 48, 2, 0, 64'h09a1 << 48);
    chk("host sel down", 16'h0, HOST_PATH_SELECT);
    xfer(64'h08b2 << 48, 2, 0, 64'h08b2 << 48);
    chk("host sel up", 16'h1, HOST_PATH_SELECT);
    xfer(64'h021034125a000000, 5, 0, 64'h021034125a000000);
    chk("bcast strobe", 16'h1, strobes[15:0]);
    chk("bcast data", 16'h1234, WRITE_DATA);
    chk("bcast reg", 16'h10, REG_ADDR);
    // Own single write with the alive byte present
    ALIVE_COUNTER_ENABLE = 1;
    xfer(64'h1c1178566b070000, 6, 0, 64'h1c1178566b070000);
    ALIVE_COUNTER_ENABLE = 0;
    chk("own write", 16'h5678, WRITE_DATA);
    xfer(64'h241178566b000000, 5, 0, 64'h241178566b000000);
    chk("other write", 16'h2, strobes[15:0]);
    xfer(64'h0212cdab00000000, 5, 1, 64'h0212cdab00000000);
    chk("bad write", 16'h2, strobes[15:0]);
    chk("crc flags", 16'h5, {UP_PATH_CRC_ERROR, DOWN_PATH_CRC_ERROR,
        CRC_ERROR_ROLLUP});
    CLEAR_CRC_FLAGS = 1;
    @(negedge CORE_CLK);
    CLEAR_CRC_FLAGS = 0;
    // Enabled: diag B, block OV, block UV, cal, aux UV, cell UV; seed bit 0 kept
    xfer(64'h1d20c2d301770000, 6, 0, 64'h1d20efbe6b770000);
    xfer(64'h2520c2d300770000, 6, 0, 64'h2520c2d300770000);
    // Invalid register: no fill nor data-check substitution
    REG_VALID = 0;
    xfer(64'h1d21c2d301770000, 6, 0, 64'h1d21c2d301770000);
    REG_VALID = 1;
    RX_PATH_UP = 0;
    // Everything masked but the reset alert, with a check error
    ALERT_ENABLE = 12'h0;
    POWER_ON_RESET_ALERT = 1;
    xfer(64'h0e30c2d300550000, 6, 1, 64'h0e30efbea0550000);
    chk("flag kept", 16'h1, CRC_ERROR_ROLLUP);
    chk("down flags", 16'h3, {UP_PATH_CRC_ERROR, DOWN_PATH_CRC_ERROR,
        CRC_ERROR_ROLLUP});
    IDLE_HIGH_Z = 1;
    repeat (3) @(negedge CORE_CLK);
    chk("high-z idle", 16'h0, {TX_POSITIVE_OE, TX_NEGATIVE_OE});
    report_and_stop;
  end
endmodule
